// *** hdl/ufc_pkg.sv ***
// Package with register map, field positions and constants of the UART FIFO control block
package ufc_pkg;
	// Register byte offsets, one aligned word each
	localparam logic [4:0] UFC_DATA_OFF = 5'h00;
	localparam logic [4:0] UFC_INT_EN_OFF = 5'h04;
	localparam logic [4:0] UFC_FIFO_CTRL_OFF = 5'h08;
	localparam logic [4:0] UFC_LINE_FMT_OFF = 5'h0C;
	localparam logic [4:0] UFC_STATUS_OFF = 5'h10;
	// FIFO control field positions
	localparam int UFC_FC_MODE_EN_BIT = 0;
	localparam int UFC_FC_RX_FLUSH_BIT = 1;
	localparam int UFC_FC_TX_FLUSH_BIT = 2;
	localparam int UFC_FC_DMA_BIT = 3;
	localparam int UFC_FC_TRIG_LSB = 6;
	localparam int UFC_FC_TRIG_MSB = 7;
	// Interrupt enable field positions
	localparam int UFC_IE_RX_DATA_BIT = 0;
	// Status field positions
	localparam int UFC_ST_RX_CNT_LSB = 0;
	localparam int UFC_ST_TX_CNT_LSB = 8;
	localparam int UFC_ST_MODE_BIT = 16;
	localparam int UFC_ST_DMA_BIT = 17;
	localparam int UFC_ST_TRIG_LSB = 18;
	// Values after reset
	localparam logic [7:0] UFC_LINE_FMT_RESET = 8'h00;
	localparam logic [1:0] UFC_TRIG_RESET = 2'h0;
	localparam logic [31:0] UFC_RDATA_RESET = 32'h0000_0000;
	// Receive trigger thresholds in bytes
	localparam logic [4:0] UFC_TRIG_1 = 5'h01;
	localparam logic [4:0] UFC_TRIG_4 = 5'h04;
	localparam logic [4:0] UFC_TRIG_8 = 5'h08;
	localparam logic [4:0] UFC_TRIG_14 = 5'h0E;
	// Depth, and holding depth in non-FIFO mode
	localparam int UFC_FIFO_DEPTH = 16;
	localparam logic [4:0] UFC_SINGLE_DEPTH = 5'h01;
	// Receive timeout in character times
	localparam logic [2:0] UFC_TIMEOUT_CHARS = 3'h4;
	// Interrupt identification codes, low nibble
	localparam logic [3:0] UFC_IDENT_NONE = 4'h1;
	localparam logic [3:0] UFC_IDENT_RX_DATA = 4'h4;
	localparam logic [3:0] UFC_IDENT_RX_TIMEOUT = 4'hC;
	localparam int UFC_IDENT_MODE_LSB = 6;
endpackage

// *** hdl/ufc_fifo.sv ***
// Parameterised FIFO with registered read data, flush and a depth cap
module ufc_fifo
	import ufc_pkg::*;
#(
	parameter int WIDTH = 8,
	parameter int DEPTH = 16,
	parameter int CW = $clog2(DEPTH + 1)
) (
	input wire logic clock,
	input wire logic nrst,
	input wire logic flush,
	input wire logic [CW-1:0] cap,
	input wire logic in_valid,
	input wire logic [WIDTH-1:0] in_data,
	output logic in_ready,
	output logic out_valid,
	output logic [WIDTH-1:0] out_data,
	input wire logic out_ready,
	output logic [CW-1:0] count
);
	localparam int PW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem_reg [DEPTH];
	logic [PW-1:0] wr_ptr_reg;
	logic [PW-1:0] rd_ptr_reg;
	logic [PW-1:0] rd_ptr_next;
	logic [CW-1:0] count_reg;
	logic [WIDTH-1:0] out_data_reg;
	logic push;
	logic pop;

	// Handshakes; the cap shrinks the FIFO to a holding register
	assign in_ready = !flush && (count_reg < cap);
	assign out_valid = count_reg != '0;
	assign push = in_valid && in_ready;
	assign pop = out_valid && out_ready && !flush;
	assign rd_ptr_next = pop ? PW'(rd_ptr_reg + 1'b1) : rd_ptr_reg;
	assign out_data = out_data_reg;
	assign count = count_reg;

	// Storage array, no reset needed
	always_ff @(posedge clock) begin
		if (push) begin
			mem_reg[wr_ptr_reg] <= in_data;
		end
	end

	// Pointers and fill count; flush wins over any transfer
	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			wr_ptr_reg <= '0;
			rd_ptr_reg <= '0;
			count_reg <= '0;
		end else if (flush) begin
			wr_ptr_reg <= '0;
			rd_ptr_reg <= '0;
			count_reg <= '0;
		end else begin
			if (push) begin
				wr_ptr_reg <= PW'(wr_ptr_reg + 1'b1);
			end
			rd_ptr_reg <= rd_ptr_next;
			count_reg <= CW'(count_reg + CW'(push) - CW'(pop));
		end
	end

	// Head word, forwarded when it is being written this cycle
	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			out_data_reg <= '0;
		end else if (push && (wr_ptr_reg == rd_ptr_next)) begin
			out_data_reg <= in_data;
		end else begin
			out_data_reg <= mem_reg[rd_ptr_next];
		end
	end
endmodule

// *** hdl/ufc_top.sv ***
// UART FIFO control: mode, flushes, receive trigger, timeout and DMA mode
// Behaviour
// - Two-bit trigger field picks threshold of 1, 4, 8 or 14 bytes.
// - Receive data-ready interrupt rises once fill reaches threshold and it is enabled.
// - Receive data-ready interrupt drops once fill falls under the threshold.
// - Bit 3 turns on DMA mode one, effective only while FIFOs are on.
// - Writing 1 to bit 2 empties the transmit FIFO; shifter untouched.
// - Writing 1 to bit 1 empties the receive FIFO; shifter untouched.
// - Both flush bits clear themselves after one flush.
// - Other control fields are ignored unless FIFO mode is already on.
// - Clearing FIFO mode disables both FIFOs and zeroes their counts.
// - Setting FIFO mode turns on both FIFOs together.
// - Line format register reads back what software wrote.
// - Control address reads identification, writes control, regardless of divisor bit.
// - Receive timeout after four idle character times with data waiting, in FIFO mode only.
module ufc_top
	import ufc_pkg::*;
#(
	parameter int DEPTH = UFC_FIFO_DEPTH
) (
	input wire logic clock,
	input wire logic nrst,
	input wire logic [4:0] reg_addr,
	input wire logic [31:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [31:0] reg_rdata,
	input wire logic rx_char_valid,
	input wire logic [7:0] rx_char_data,
	output logic rx_char_ready,
	output logic tx_char_valid,
	output logic [7:0] tx_char_data,
	input wire logic tx_char_ready,
	input wire logic char_tick,
	output logic [7:0] line_format,
	output logic rx_data_ready_irq,
	output logic rx_timeout_irq,
	output logic dma_rx_req,
	output logic dma_tx_req
);
	localparam int CW = $clog2(DEPTH + 1);

	logic fifo_mode_en_reg;
	logic dma_mode_one_en_reg;
	logic [1:0] rx_trigger_level_sel_reg;
	logic tx_flush_reg;
	logic rx_flush_reg;
	logic rx_data_en_reg;
	logic [7:0] line_format_reg;
	logic [31:0] reg_rdata_reg;
	logic rx_data_ready_reg;
	logic rx_timeout_reg;
	logic [2:0] idle_chars_reg;
	logic [CW-1:0] rx_count;
	logic [CW-1:0] tx_count;
	logic [CW-1:0] cap;
	logic [CW-1:0] threshold;
	logic [7:0] rx_head;
	logic rx_head_valid;
	logic rx_push;
	logic rx_pop;
	logic tx_in_ready;
	logic fc_write;
	logic [3:0] ident_code;
	logic [31:0] interrupt_ident_reg;
	logic [31:0] status_word;

	// Address match, used by every decode
	function automatic logic addr_hit(input logic [4:0] addr, input logic [4:0] off);
		return addr == off;
	endfunction

	// Trigger code to threshold in bytes
	function automatic logic [4:0] trig_bytes(input logic [1:0] sel);
		unique case (sel)
			2'h0: return UFC_TRIG_1;
			2'h1: return UFC_TRIG_4;
			2'h2: return UFC_TRIG_8;
			2'h3: return UFC_TRIG_14;
		endcase
	endfunction

	assign fc_write = reg_wr && addr_hit(reg_addr, UFC_FIFO_CTRL_OFF);
	assign threshold = fifo_mode_en_reg ? CW'(trig_bytes(rx_trigger_level_sel_reg))
		: CW'(UFC_TRIG_1);
	assign cap = fifo_mode_en_reg ? CW'(DEPTH) : CW'(UFC_SINGLE_DEPTH);
	assign rx_pop = reg_rd && addr_hit(reg_addr, UFC_DATA_OFF) && rx_head_valid;
	assign rx_push = rx_char_valid && rx_char_ready;

	// FIFO mode enable, written at any time
	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			fifo_mode_en_reg <= 1'b0;
		end else if (fc_write) begin
			fifo_mode_en_reg <= reg_wdata[UFC_FC_MODE_EN_BIT];
		end
	end

	// Other control fields, taken only while FIFO mode already stands
	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			dma_mode_one_en_reg <= 1'b0;
			rx_trigger_level_sel_reg <= UFC_TRIG_RESET;
		end else if (fc_write && fifo_mode_en_reg) begin
			dma_mode_one_en_reg <= reg_wdata[UFC_FC_DMA_BIT];
			rx_trigger_level_sel_reg <= reg_wdata[UFC_FC_TRIG_MSB:UFC_FC_TRIG_LSB];
		end
	end

	// One-cycle flush pulses; leaving FIFO mode flushes both
	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			tx_flush_reg <= 1'b0;
			rx_flush_reg <= 1'b0;
		end else begin
			tx_flush_reg <= fc_write && ((fifo_mode_en_reg && reg_wdata[UFC_FC_TX_FLUSH_BIT])
				|| !reg_wdata[UFC_FC_MODE_EN_BIT]);
			rx_flush_reg <= fc_write && ((fifo_mode_en_reg && reg_wdata[UFC_FC_RX_FLUSH_BIT])
				|| !reg_wdata[UFC_FC_MODE_EN_BIT]);
		end
	end

	// Interrupt enable and line format storage
	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			rx_data_en_reg <= 1'b0;
			line_format_reg <= UFC_LINE_FMT_RESET;
		end else if (reg_wr) begin
			if (addr_hit(reg_addr, UFC_INT_EN_OFF)) begin
				rx_data_en_reg <= reg_wdata[UFC_IE_RX_DATA_BIT];
			end
			if (addr_hit(reg_addr, UFC_LINE_FMT_OFF)) begin
				line_format_reg <= reg_wdata[7:0];
			end
		end
	end

	// Receive path: link characters into the FIFO, software pops them
	ufc_fifo #(.WIDTH(8), .DEPTH(DEPTH), .CW(CW)) u_rx_fifo (
		.clock(clock),
		.nrst(nrst),
		.flush(rx_flush_reg),
		.cap(cap),
		.in_valid(rx_char_valid),
		.in_data(rx_char_data),
		.in_ready(rx_char_ready),
		.out_valid(rx_head_valid),
		.out_data(rx_head),
		.out_ready(rx_pop),
		.count(rx_count)
	);

	// Transmit path: software pushes, the shifter drains
	ufc_fifo #(.WIDTH(8), .DEPTH(DEPTH), .CW(CW)) u_tx_fifo (
		.clock(clock),
		.nrst(nrst),
		.flush(tx_flush_reg),
		.cap(cap),
		.in_valid(reg_wr && addr_hit(reg_addr, UFC_DATA_OFF)),
		.in_data(reg_wdata[7:0]),
		.in_ready(tx_in_ready),
		.out_valid(tx_char_valid),
		.out_data(tx_char_data),
		.out_ready(tx_char_ready),
		.count(tx_count)
	);

	// Idle character counter; any receive FIFO traffic restarts it
	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			idle_chars_reg <= '0;
		end else if (!fifo_mode_en_reg || rx_count == '0 || rx_push || rx_pop || rx_flush_reg) begin
			idle_chars_reg <= '0;
		end else if (char_tick && idle_chars_reg != UFC_TIMEOUT_CHARS) begin
			idle_chars_reg <= idle_chars_reg + 3'h1;
		end
	end

	// Registered receive interrupts, level with the fill count and the idle counter
	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			rx_data_ready_reg <= 1'b0;
			rx_timeout_reg <= 1'b0;
		end else begin
			rx_data_ready_reg <= rx_data_en_reg && rx_count >= threshold;
			rx_timeout_reg <= rx_data_en_reg && idle_chars_reg == UFC_TIMEOUT_CHARS;
		end
	end

	// Identification word, data-ready ahead of timeout
	always_comb begin
		if (rx_data_ready_reg) begin
			ident_code = UFC_IDENT_RX_DATA;
		end else if (rx_timeout_reg) begin
			ident_code = UFC_IDENT_RX_TIMEOUT;
		end else begin
			ident_code = UFC_IDENT_NONE;
		end
		interrupt_ident_reg = {24'h00_0000, {2{fifo_mode_en_reg}}, 2'h0, ident_code};
		status_word = '0;
		status_word[UFC_ST_RX_CNT_LSB +: CW] = rx_count;
		status_word[UFC_ST_TX_CNT_LSB +: CW] = tx_count;
		status_word[UFC_ST_MODE_BIT] = fifo_mode_en_reg;
		status_word[UFC_ST_DMA_BIT] = dma_mode_one_en_reg;
		status_word[UFC_ST_TRIG_LSB +: 2] = rx_trigger_level_sel_reg;
	end

	// Read data, one cycle after the strobe; unmapped reads give zero
	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			reg_rdata_reg <= UFC_RDATA_RESET;
		end else if (reg_rd) begin
			if (addr_hit(reg_addr, UFC_DATA_OFF)) begin
				reg_rdata_reg <= {24'h00_0000, rx_head};
			end else if (addr_hit(reg_addr, UFC_INT_EN_OFF)) begin
				reg_rdata_reg <= {31'h0000_0000, rx_data_en_reg};
			end else if (addr_hit(reg_addr, UFC_FIFO_CTRL_OFF)) begin
				reg_rdata_reg <= interrupt_ident_reg;
			end else if (addr_hit(reg_addr, UFC_LINE_FMT_OFF)) begin
				reg_rdata_reg <= {24'h00_0000, line_format_reg};
			end else if (addr_hit(reg_addr, UFC_STATUS_OFF)) begin
				reg_rdata_reg <= status_word;
			end else begin
				reg_rdata_reg <= UFC_RDATA_RESET;
			end
		end
	end

	// Outputs; DMA requests need DMA mode one and FIFO mode
	assign reg_rdata = reg_rdata_reg;
	assign line_format = line_format_reg;
	assign rx_data_ready_irq = rx_data_ready_reg;
	assign rx_timeout_irq = rx_timeout_reg;
	assign dma_rx_req = fifo_mode_en_reg && dma_mode_one_en_reg
		&& (rx_data_ready_reg || rx_timeout_reg);
	assign dma_tx_req = fifo_mode_en_reg && dma_mode_one_en_reg && tx_in_ready;

	// Checks
	property p_trig_14;
		@(posedge clock) disable iff (!nrst)
		fifo_mode_en_reg && rx_trigger_level_sel_reg == 2'h3 && rx_count == CW'(13)
		|=> !rx_data_ready_irq;
	endproperty
	a_trig_14: assert property (p_trig_14) else $error("Trigger 14 fired early");

	property p_rx_ready_rise;
		@(posedge clock) disable iff (!nrst)
		rx_data_en_reg && rx_count >= threshold |=> rx_data_ready_irq;
	endproperty
	a_rx_ready_rise: assert property (p_rx_ready_rise) else $error("Data-ready missing");

	property p_rx_ready_fall;
		@(posedge clock) disable iff (!nrst)
		rx_count < threshold |=> !rx_data_ready_irq;
	endproperty
	a_rx_ready_fall: assert property (p_rx_ready_fall) else $error("Data-ready stuck");

	property p_dma_gated;
		@(posedge clock) disable iff (!nrst)
		(dma_rx_req || dma_tx_req) |-> fifo_mode_en_reg && dma_mode_one_en_reg;
	endproperty
	a_dma_gated: assert property (p_dma_gated) else $error("DMA request without mode");

	property p_tx_flush;
		@(posedge clock) disable iff (!nrst)
		fc_write && fifo_mode_en_reg && reg_wdata[UFC_FC_TX_FLUSH_BIT] |=> ##1 tx_count == '0;
	endproperty
	a_tx_flush: assert property (p_tx_flush) else $error("Transmit flush failed");

	property p_rx_flush;
		@(posedge clock) disable iff (!nrst)
		fc_write && fifo_mode_en_reg && reg_wdata[UFC_FC_RX_FLUSH_BIT] |=> ##1 rx_count == '0;
	endproperty
	a_rx_flush: assert property (p_rx_flush) else $error("Receive flush failed");

	property p_flush_self_clear;
		@(posedge clock) disable iff (!nrst)
		!fc_write |=> !tx_flush_reg && !rx_flush_reg;
	endproperty
	a_flush_self_clear: assert property (p_flush_self_clear) else $error("Flush held");

	property p_ignored_when_off;
		@(posedge clock) disable iff (!nrst)
		fc_write && !fifo_mode_en_reg |=> $stable(rx_trigger_level_sel_reg)
			&& $stable(dma_mode_one_en_reg);
	endproperty
	a_ignored_when_off: assert property (p_ignored_when_off) else $error("Field taken");

	property p_mode_off_clears;
		@(posedge clock) disable iff (!nrst)
		$fell(fifo_mode_en_reg) |=> rx_count == '0 && tx_count == '0;
	endproperty
	a_mode_off_clears: assert property (p_mode_off_clears) else $error("Counts kept");

	property p_mode_on;
		@(posedge clock) disable iff (!nrst)
		fc_write && reg_wdata[UFC_FC_MODE_EN_BIT] |=> fifo_mode_en_reg && cap == CW'(DEPTH);
	endproperty
	a_mode_on: assert property (p_mode_on) else $error("FIFO mode not on");

	property p_line_fmt_read;
		@(posedge clock) disable iff (!nrst)
		reg_rd && addr_hit(reg_addr, UFC_LINE_FMT_OFF)
		|=> reg_rdata == {24'h00_0000, $past(line_format_reg)};
	endproperty
	a_line_fmt_read: assert property (p_line_fmt_read) else $error("Format readback");

	property p_ident_read;
		@(posedge clock) disable iff (!nrst)
		reg_rd && addr_hit(reg_addr, UFC_FIFO_CTRL_OFF) && !rx_data_ready_reg && !rx_timeout_reg
		|=> reg_rdata[3:0] == UFC_IDENT_NONE && reg_rdata[31:8] == 24'h00_0000;
	endproperty
	a_ident_read: assert property (p_ident_read) else $error("Ident read wrong");

	property p_timeout;
		@(posedge clock) disable iff (!nrst)
		rx_timeout_irq |-> fifo_mode_en_reg && rx_count != '0 || $past(rx_count) != '0;
	endproperty
	a_timeout: assert property (p_timeout) else $error("Timeout while empty");

	c_flush: cover property (@(posedge clock) disable iff (!nrst) rx_flush_reg && rx_count != '0);
	c_trig: cover property (@(posedge clock) disable iff (!nrst) $rose(rx_data_ready_irq));
	c_timeout: cover property (@(posedge clock) disable iff (!nrst) $rose(rx_timeout_irq));
	c_full: cover property (@(posedge clock) disable iff (!nrst) !tx_in_ready && fifo_mode_en_reg);
endmodule

// *** dv/ufc_line_model.sv ***
// Serial-side model: receive character source, transmit sink and character tick
module ufc_line_model (
	input wire logic clock,
	input wire logic nrst,
	input wire logic [7:0] rx_send,
	output logic rx_char_valid,
	output logic [7:0] rx_char_data,
	input wire logic rx_char_ready,
	input wire logic tx_accept,
	input wire logic tx_char_valid,
	input wire logic [7:0] tx_char_data,
	output logic tx_char_ready,
	output logic [7:0] tx_taken,
	output logic [7:0] tx_last,
	input wire logic tick_en,
	output logic char_tick
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [7:0] sent_reg;
	logic [2:0] tick_reg;
	// Count characters taken; offer more until the requested total is reached
	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst)
			sent_reg <= 8'h00;
		else if (rx_char_valid && rx_char_ready)
			sent_reg <= sent_reg + 8'h01;
	end
	assign rx_char_valid = nrst && (sent_reg != rx_send);
	assign rx_char_data = rx_char_valid ? sent_reg : ~sent_reg; // No stale value when idle
	// Sink takes the head only while the bench allows it
	assign tx_char_ready = tx_accept;
	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			tx_taken <= 8'h00;
			tx_last <= 8'h00;
		end else if (tx_char_valid && tx_char_ready) begin
			tx_taken <= tx_taken + 8'h01;
			tx_last <= tx_char_data;
		end
	end
	// One character time every eight clocks
	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst)
			tick_reg <= 3'h0;
		else
			tick_reg <= tick_reg + 3'h1;
	end
	assign char_tick = tick_en && (tick_reg == 3'h7);
endmodule

// *** dv/test_uart_fifo_control.sv ***
// Self-checking testbench of the UART FIFO control block
module test_uart_fifo_control import ufc_pkg::*;;
	timeunit 1ns;
	timeprecision 1ns;
	logic clock, nrst, reg_wr, reg_rd, rx_char_valid, rx_char_ready, tx_char_valid;
	logic tx_char_ready, char_tick, rx_data_ready_irq, rx_timeout_irq, dma_rx_req, dma_tx_req;
	logic tx_accept, tick_en;
	logic [4:0] reg_addr;
	logic [31:0] reg_wdata, reg_rdata, v;
	logic [7:0] rx_char_data, tx_char_data, line_format, rx_send, tx_taken, tx_last, base;
	int bad_count, samples_checked;
	ufc_top DUT (.clock(clock), .nrst(nrst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
		.rx_char_valid(rx_char_valid), .rx_char_data(rx_char_data),
		.rx_char_ready(rx_char_ready), .tx_char_valid(tx_char_valid),
		.tx_char_data(tx_char_data), .tx_char_ready(tx_char_ready), .char_tick(char_tick),
		.line_format(line_format), .rx_data_ready_irq(rx_data_ready_irq),
		.rx_timeout_irq(rx_timeout_irq), .dma_rx_req(dma_rx_req), .dma_tx_req(dma_tx_req));
	ufc_line_model u_line (.clock(clock), .nrst(nrst), .rx_send(rx_send),
		.rx_char_valid(rx_char_valid), .rx_char_data(rx_char_data),
		.rx_char_ready(rx_char_ready), .tx_accept(tx_accept), .tx_char_valid(tx_char_valid),
		.tx_char_data(tx_char_data), .tx_char_ready(tx_char_ready), .tx_taken(tx_taken),
		.tx_last(tx_last), .tick_en(tick_en), .char_tick(char_tick));
	// Compare and count
	task check(input logic [31:0] seen, input logic [31:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			bad_count++;
			$display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	// Verdict and end of run
	task summarize();
		if (bad_count == 0 && samples_checked > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	// Register bus write and read, one-cycle strobes
	task wr(input logic [4:0] a, input logic [31:0] d);
		@(posedge clock);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge clock);
		reg_wr <= 1'b0;
	endtask
	task rd(input logic [4:0] a, output logic [31:0] d);
		@(posedge clock);
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge clock);
		reg_rd <= 1'b0;
		@(posedge clock);
		d = reg_rdata;
	endtask
	task rd_check(input logic [4:0] a, input logic [31:0] exp);
		rd(a, v);
		check(v, exp);
	endtask
	// Wait until the model has handed over every requested character
	task settle();
		int n;
		n = 0;
		@(posedge clock);
		while (rx_char_valid && n < 100) begin
			@(posedge clock);
			n++;
		end
		check(rx_char_valid, 1'b0);
		repeat (3) @(posedge clock);
	endtask
	// Reset values, unmapped read, line format, control ignored until mode is on
	task t_reset();
		rd_check(UFC_STATUS_OFF, 32'h0000_0000);
		rd_check(5'h14, 32'h0000_0000);
		wr(UFC_LINE_FMT_OFF, 32'h0000_00A5);
		rd_check(UFC_LINE_FMT_OFF, 32'h0000_00A5);
		check(line_format, 8'hA5);
		rd_check(UFC_FIFO_CTRL_OFF, 32'h0000_0001);
		wr(UFC_FIFO_CTRL_OFF, 32'h0000_00C8);
		rd_check(UFC_STATUS_OFF, 32'h0000_0000);
		wr(UFC_FIFO_CTRL_OFF, 32'h0000_00C9);
		rd_check(UFC_STATUS_OFF, 32'h0001_0000);
		wr(UFC_FIFO_CTRL_OFF, 32'h0000_00C9);
		rd_check(UFC_STATUS_OFF, 32'h000F_0000);
		rd_check(UFC_FIFO_CTRL_OFF, 32'h0000_00C1);
		wr(UFC_FIFO_CTRL_OFF, 32'hFFFF_FF39);
		rd_check(UFC_STATUS_OFF, 32'h0003_0000);
	endtask
	// Each trigger code: interrupt rises at its threshold, falls after one pop
	task t_trigger();
		logic [4:0] thr [4];
		thr = '{5'h01, 5'h04, 5'h08, 5'h0E};
		wr(UFC_INT_EN_OFF, 32'h0000_0001);
		for (int c = 0; c < 4; c++) begin
			wr(UFC_FIFO_CTRL_OFF, {24'h00_0000, c[1:0], 6'h0B});
			rd(UFC_STATUS_OFF, v);
			check(v & 32'h000C_001F, {12'h000, c[1:0], 18'h0_0000});
			base = rx_send;
			rx_send <= rx_send + 8'(thr[c] - 5'h01);
			settle();
			check(rx_data_ready_irq, 1'b0);
			rx_send <= rx_send + 8'h01;
			settle();
			check(rx_data_ready_irq, 1'b1);
			rd_check(UFC_FIFO_CTRL_OFF, 32'h0000_00C4);
			rd_check(UFC_DATA_OFF, {24'h00_0000, base});
			repeat (2) @(posedge clock);
			check(rx_data_ready_irq, 1'b0);
		end
	endtask
	// Receive FIFO fills to its depth, refuses, then drains in order
	task t_fill();
		wr(UFC_FIFO_CTRL_OFF, 32'h0000_000B);
		base = rx_send;
		rx_send <= rx_send + 8'h14;
		repeat (30) @(posedge clock);
		rd_check(UFC_STATUS_OFF, 32'h0003_0010);
		check(rx_char_ready, 1'b0);
		for (int i = 0; i < 20; i++)
			rd_check(UFC_DATA_OFF, {24'h00_0000, 8'(base + i[7:0])});
		rd_check(UFC_STATUS_OFF, 32'h0003_0000);
	endtask
	// Timeout after four idle character times with data waiting
	task t_timeout();
		wr(UFC_FIFO_CTRL_OFF, 32'h0000_00CB);
		rx_send <= rx_send + 8'h02;
		settle();
		tick_en <= 1'b1;
		repeat (16) @(posedge clock);
		check(rx_timeout_irq, 1'b0);
		repeat (32) @(posedge clock);
		check(rx_timeout_irq, 1'b1);
		check(dma_rx_req, 1'b1);
		rd_check(UFC_FIFO_CTRL_OFF, 32'h0000_00CC);
		tick_en <= 1'b0;
		rd(UFC_DATA_OFF, v);
		repeat (2) @(posedge clock);
		check(rx_timeout_irq, 1'b0);
	endtask
	// Transmit FIFO fills while the sink stalls, is flushed, then drains
	task t_tx();
		for (int i = 0; i < 17; i++)
			wr(UFC_DATA_OFF, {24'h00_0000, i[7:0]});
		rd(UFC_STATUS_OFF, v);
		check(v & 32'h0000_1F00, 32'h0000_1000);
		check(dma_tx_req, 1'b0);
		wr(UFC_FIFO_CTRL_OFF, 32'h0000_00CD);
		repeat (2) @(posedge clock);
		rd(UFC_STATUS_OFF, v);
		check(v & 32'h0000_1F00, 32'h0000_0000);
		check(tx_char_valid, 1'b0);
		check(dma_tx_req, 1'b1);
		wr(UFC_DATA_OFF, 32'h0000_005A);
		wr(UFC_DATA_OFF, 32'h0000_003C);
		tx_accept <= 1'b1;
		repeat (4) @(posedge clock);
		check({tx_taken, tx_last}, 16'h023C);
	endtask
	// Leaving FIFO mode empties both FIFOs; then one-deep holding with DMA gated off
	task t_mode_off();
		wr(UFC_FIFO_CTRL_OFF, 32'h0000_0008);
		repeat (2) @(posedge clock);
		rd(UFC_STATUS_OFF, v);
		check(v & 32'h0001_1F1F, 32'h0000_0000);
		rd_check(UFC_FIFO_CTRL_OFF, 32'h0000_0001);
		base = rx_send;
		rx_send <= rx_send + 8'h01;
		settle();
		check(rx_data_ready_irq, 1'b1);
		check(dma_rx_req, 1'b0);
		rd_check(UFC_FIFO_CTRL_OFF, 32'h0000_0004);
		rd_check(UFC_DATA_OFF, {24'h00_0000, base});
	endtask
	// Clock of 50 ns period
	always #25 clock = ~clock;
	// Main sequence
	initial begin
		clock = 1'b0;
		nrst = 1'b0;
		reg_addr = 5'h00;
		reg_wdata = 32'h0000_0000;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		rx_send = 8'h00;
		tx_accept = 1'b0;
		tick_en = 1'b0;
		bad_count = 0;
		samples_checked = 0;
		repeat (3) @(posedge clock);
		nrst <= 1'b1;
		t_reset();
		t_trigger();
		t_fill();
		t_timeout();
		t_tx();
		t_mode_off();
		summarize();
	end
	// Watchdog well beyond the expected run length
	initial begin
		#(50 * 20000);
		bad_count++;
		summarize();
	end
endmodule
